//--- shared/ssp_pkg.sv
// Purpose: Shared constants for the synchronous serial port
// Assumes: APB slave with 32-bit words, one register per aligned word
// Notes:   Offsets are byte addresses on the low 8 address bits
package ssp_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LINE = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_FCTL = 8'h0c;
    localparam logic [7:0] ADDR_CNT  = 8'h10;
    localparam logic [7:0] ADDR_TXD  = 8'h14;
    localparam logic [7:0] ADDR_RXD  = 8'h18;
    localparam logic [7:0] ADDR_BAUD = 8'h1c;

    // ==========================================================
    // Field positions
    localparam int CTRL_TE     = 0;
    localparam int CTRL_RE     = 1;
    localparam int CTRL_TIE    = 2;
    localparam int CTRL_RIE    = 3;
    localparam int CTRL_INTCLK = 4;
    localparam int CTRL_W      = 5;
    localparam int LINE_OVR    = 0;
    localparam int LINE_STOP_COUNT_ENABLE   = 1;
    localparam int LINE_FST_LO = 8;
    localparam int LINE_FST_HI = 14;
    localparam int FST_W       = 7;
    localparam int STAT_RDONE  = 0;
    localparam int STAT_TDONE  = 1;
    localparam int STAT_TX_END_FLAG   = 2;
    localparam int FCTL_RRST   = 0;
    localparam int FCTL_TRST   = 1;

    // ==========================================================
    // Reset values and counts
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [7:0]        BAUD_RST = 8'h03;
    localparam int                CNT_W    = 9;
    localparam logic [8:0]        NOSTOP_BYTES = 9'h180;
    localparam logic [2:0]        LAST_BIT     = 3'h7;
    localparam logic [3:0]        LAST_HALF    = 4'hf;
    localparam int                FIFO_DEPTH   = 128;

    typedef enum logic [1:0] {
        GEN_IDLE = 2'b01,
        GEN_RUN  = 2'b10
    } ssp_gen_e;
endpackage

//--- src/ssp_fifo.sv
// Purpose: Byte FIFO for the serial port
// Assumes: DEPTH is a power of two
// Notes:   Read data is the head entry, valid while not empty
module ssp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 128,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         clr,
    input  wire logic         push,
    input  wire logic [W-1:0] wdata,
    input  wire logic         pop,
    output logic      [W-1:0] rdata,
    output logic      [AW:0]  level,
    output logic              full,
    output logic              empty
);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   level_q;
    wire           push_ok;
    wire           pop_ok;

    // ==========================================================
    // Status
    assign full    = (level_q == (AW+1)'(DEPTH));
    assign empty   = (level_q == '0);
    assign level   = level_q;
    assign push_ok = push & ~full;
    assign pop_ok  = pop & ~empty;
    // Empty read shows a stale entry, no guard needed
    assign rdata   = mem[rd_q];

    // ==========================================================
    // Pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q    <= '0;
            rd_q    <= '0;
            level_q <= '0;
        end else if (clr) begin
            wr_q    <= '0;
            rd_q    <= '0;
            level_q <= '0;
        end else begin
            wr_q    <= wr_q + AW'(push_ok);
            rd_q    <= rd_q + AW'(pop_ok);
            level_q <= level_q + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
        end
    end

    always_ff @(posedge clk) begin
        if (push_ok) begin
            mem[wr_q] <= wdata;
        end
    end
endmodule

//--- src/ssp_top.sv
// Purpose: Synchronous serial port with stop counters, APB registers
// Assumes: pclk 50 MHz; serial pins asynchronous to pclk
// Notes:   Serial clock idles high; data out on fall, sampled on rise
//
// Contract
// R1: Reception starts only once serial clock toggles, internal or external.
// R2: Incoming bits shift in LSB first, byte then moves to receive FIFO.
// R3: Stop after programmed count when enabled, else after 384 bytes.
// R4: Receive-done sets when the last counted byte enters receive FIFO.
// R5: Transmit-done and transmit-end set when last byte enters shift register.
// R6: Separate transmit and receive interrupt outputs, each with own enable.
// R7: Transmit interrupt asserts while transmit-done and its enable; usable for DMA.
// R8: Receive interrupt asserts while receive-done and its enable; usable for DMA.
// R9: Receive interrupt source ranks above transmit source.
// R10: Host sets transmit and receive enable in one write for full duplex.
// R11: Clearing both done flags in one write restarts full-duplex transfer.
// R12: No reception while overrun flag set; host reads then clears it.
// R13: Host reloads count with stop enable while receive-done still set.
// R14: Writes to a full transmit FIFO are discarded.
// R15: Reading an empty receive FIFO returns an undefined value.
// R16: Transmit stop counter latches on enable rise or while transmit-done set.
// R17: Receive stop counter latches on enable rise or while receive-done set.
// R18: Host writes stop count field back to zero after setting it.
// R19: Host uses only even counts except for receive-only transfers.
// R20: Interrupts are held off during a DMA burst transfer.
// R21: Receive FIFO empties while its reset bit is set.
// R22: Host sets up the DMA channel before the serial port.
// R23: Stop enabled transfers 1 to 128 bytes, otherwise up to 384.
// R24: Eight clock pulses per character; clock held high when idle.
// R25: Data changes on falling clock, sampled on rising clock.
// R26: Byte completing into a full receive FIFO sets overrun, is dropped.
// R27: Done flag clears on zero write only after being read as one.
module ssp_top #(
    parameter int DEPTH = ssp_pkg::FIFO_DEPTH
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe,
    input  wire logic        rxd_i,
    output logic             txd_o,
    output logic             txd_oe,
    input  wire logic        dma_burst,
    output logic             tx_irq,
    output logic             rx_irq,
    output logic [1:0]       irq_code
);
    localparam int AW = $clog2(DEPTH);

    logic [ssp_pkg::CTRL_W-1:0] ctrl_q;
    logic                       stop_count_enable_q;
    logic [ssp_pkg::FST_W-1:0]  fst_q;
    logic                       ovr_q;
    logic                       rdone_q;
    logic                       tdone_q;
    logic                       tx_end_flag_q;
    logic [2:0]                 seen_q;
    logic [1:0]                 fctl_q;
    logic [7:0]                 baud_q;
    logic [ssp_pkg::CNT_W-1:0]  tx_lim_q;
    logic [ssp_pkg::CNT_W-1:0]  rx_lim_q;
    logic [ssp_pkg::CNT_W-1:0]  tx_cnt_q;
    logic [ssp_pkg::CNT_W-1:0]  rx_cnt_q;
    logic [7:0]                 tx_sh_q;
    logic [7:0]                 rx_sh_q;
    logic [2:0]                 tx_bit_q;
    logic [2:0]                 rx_bit_q;
    logic                       tx_busy_q;
    logic                       sck_s1_q;
    logic                       sck_s2_q;
    logic                       sck_s3_q;
    logic                       rxd_s1_q;
    logic                       rxd_s2_q;
    logic                       sck_q;
    logic [7:0]                 div_q;
    logic [3:0]                 half_q;
    ssp_pkg::ssp_gen_e          gen_q;
    logic [7:0]                 tx_head;
    logic [7:0]                 rx_head;
    logic [AW:0]                tx_lvl;
    logic [AW:0]                rx_lvl;
    logic                       tx_full;
    logic                       tx_empty;
    logic                       rx_full;
    logic                       rx_empty;

    // ==========================================================
    // APB decode
    wire acc      = psel & penable & pready;
    wire setup    = psel & ~penable;
    wire wr       = acc & pwrite;
    wire rd       = acc & ~pwrite;
    wire hit_ctrl = (paddr == ssp_pkg::ADDR_CTRL);
    wire hit_line = (paddr == ssp_pkg::ADDR_LINE);
    wire hit_stat = (paddr == ssp_pkg::ADDR_STAT);
    wire hit_fctl = (paddr == ssp_pkg::ADDR_FCTL);
    wire hit_cnt  = (paddr == ssp_pkg::ADDR_CNT);
    wire hit_txd  = (paddr == ssp_pkg::ADDR_TXD);
    wire hit_rxd  = (paddr == ssp_pkg::ADDR_RXD);
    wire hit_baud = (paddr == ssp_pkg::ADDR_BAUD);
    wire mapped   = hit_ctrl | hit_line | hit_stat | hit_fctl
                  | hit_cnt | hit_txd | hit_rxd | hit_baud;

    wire te     = ctrl_q[ssp_pkg::CTRL_TE];
    wire re     = ctrl_q[ssp_pkg::CTRL_RE];
    wire intclk = ctrl_q[ssp_pkg::CTRL_INTCLK];

    // Read data is captured in setup, so a wait-free access phase works
    wire [31:0] rd_mux =
        hit_ctrl ? {27'h0, ctrl_q} :
        hit_line ? {17'h0, fst_q, 6'h00, stop_count_enable_q, ovr_q} :
        hit_stat ? {29'h0, tx_end_flag_q, tdone_q, rdone_q} :
        hit_fctl ? {30'h0, fctl_q} :
        hit_cnt  ? {16'(tx_lvl), 16'(rx_lvl)} :
        hit_baud ? {24'h0, baud_q} :
        hit_rxd  ? {24'h0, rx_head} : 32'h0; // R15

    // ==========================================================
    // Register write effects
    wire wr_line  = wr & hit_line;
    wire wr_stat  = wr & hit_stat;
    wire stop_count_enable_new = pwdata[ssp_pkg::LINE_STOP_COUNT_ENABLE];
    wire [ssp_pkg::FST_W-1:0] fst_new =
        wr_line ? pwdata[ssp_pkg::LINE_FST_HI:ssp_pkg::LINE_FST_LO] : fst_q;
    wire stop_count_enable_rise = wr_line & stop_count_enable_new & ~stop_count_enable_q;
    wire [ssp_pkg::CNT_W-1:0] lim_new =
        ssp_pkg::CNT_W'(fst_new) + ssp_pkg::CNT_W'(1); // R23
    wire rdone_clr = wr_stat & ~pwdata[ssp_pkg::STAT_RDONE] & seen_q[0]; // R27
    wire tdone_clr = wr_stat & ~pwdata[ssp_pkg::STAT_TDONE] & seen_q[1]; // R27
    wire ovr_clr   = wr_line & ~pwdata[ssp_pkg::LINE_OVR] & seen_q[2]; // R12
    wire push_tx   = wr & hit_txd; // R14
    wire pop_rx    = rd & hit_rxd;

    // ==========================================================
    // Serial clock edges
    wire tick      = (gen_q == ssp_pkg::GEN_RUN) & (div_q == baud_q);
    wire fall_int  = tick & sck_q;
    wire rise_int  = tick & ~sck_q;
    wire fall_ext  = sck_s3_q & ~sck_s2_q;
    wire rise_ext  = ~sck_s3_q & sck_s2_q;
    wire fall_ev   = intclk ? fall_int : fall_ext; // R25
    wire rise_ev   = intclk ? rise_int : rise_ext; // R25

    // ==========================================================
    // Transmit path
    wire [ssp_pkg::CNT_W-1:0] tx_limit = stop_count_enable_q ? tx_lim_q : ssp_pkg::NOSTOP_BYTES;
    wire tx_byte_end = tx_busy_q & rise_ev & (tx_bit_q == ssp_pkg::LAST_BIT);
    wire tx_load   = te & ~tdone_q & ~tx_empty & (~tx_busy_q | tx_byte_end);
    wire tx_last   = tx_load & ((tx_cnt_q + ssp_pkg::CNT_W'(1)) == tx_limit); // R5
    wire tx_latch  = tdone_q | stop_count_enable_rise; // R16

    // ==========================================================
    // Receive path
    wire [ssp_pkg::CNT_W-1:0] rx_limit = stop_count_enable_q ? rx_lim_q : ssp_pkg::NOSTOP_BYTES; // R3
    wire rx_run    = re & ~rdone_q & ~ovr_q; // R12
    wire rx_sample = rx_run & rise_ev; // R1
    wire rx_byte   = rx_sample & (rx_bit_q == ssp_pkg::LAST_BIT);
    wire [7:0] rx_byte_val = {rxd_s2_q, rx_sh_q[7:1]}; // R2
    wire rx_push   = rx_byte & ~rx_full;
    wire rx_ovr    = rx_byte & rx_full; // R26
    wire rx_last   = rx_push & ((rx_cnt_q + ssp_pkg::CNT_W'(1)) == rx_limit); // R4
    wire rx_latch  = rdone_q | stop_count_enable_rise; // R17

    // Internal clock runs only for loaded transmit data or receive-only
    wire want_clk  = intclk & ((te & tx_busy_q) | (~te & rx_run)); // R23
    wire irq_tx    = tdone_q & ctrl_q[ssp_pkg::CTRL_TIE] & ~dma_burst; // R7 R20
    wire irq_rx    = rdone_q & ctrl_q[ssp_pkg::CTRL_RIE] & ~dma_burst; // R8 R20

    // ==========================================================
    // APB response
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata  <= rd_mux;
                pslverr <= ~mapped;
            end
        end
    end

    // ==========================================================
    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= ssp_pkg::CTRL_RST;
            stop_count_enable_q <= 1'b0;
            fst_q  <= '0;
            fctl_q <= 2'h0;
            baud_q <= ssp_pkg::BAUD_RST;
        end else if (wr) begin
            if (hit_ctrl) begin
                ctrl_q <= pwdata[ssp_pkg::CTRL_W-1:0]; // R10
            end
            if (hit_line) begin
                stop_count_enable_q <= stop_count_enable_new;
                fst_q  <= fst_new;
            end
            if (hit_fctl) begin
                fctl_q <= pwdata[1:0];
            end
            if (hit_baud) begin
                baud_q <= pwdata[7:0];
            end
        end
    end

    // ==========================================================
    // Flags; a hardware set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdone_q <= 1'b0;
            tdone_q <= 1'b0;
            tx_end_flag_q  <= 1'b0;
            ovr_q   <= 1'b0;
            seen_q  <= 3'h0;
        end else begin
            rdone_q <= rx_last | (rdone_q & ~rdone_clr); // R4
            tdone_q <= tx_last | (tdone_q & ~tdone_clr); // R5
            tx_end_flag_q  <= tx_last | (tx_end_flag_q & ~tdone_clr); // R5
            ovr_q   <= rx_ovr | (ovr_q & ~ovr_clr); // R26
            seen_q[0] <= rdone_q & (seen_q[0] | (rd & hit_stat & prdata[ssp_pkg::STAT_RDONE]));
            seen_q[1] <= tdone_q & (seen_q[1] | (rd & hit_stat & prdata[ssp_pkg::STAT_TDONE]));
            seen_q[2] <= ovr_q & (seen_q[2] | (rd & hit_line & prdata[ssp_pkg::LINE_OVR]));
        end
    end

    // ==========================================================
    // Stop counters and byte counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_lim_q <= ssp_pkg::NOSTOP_BYTES;
            rx_lim_q <= ssp_pkg::NOSTOP_BYTES;
            tx_cnt_q <= '0;
            rx_cnt_q <= '0;
        end else begin
            if (tx_latch) begin
                tx_lim_q <= lim_new; // R16
            end
            if (rx_latch) begin
                rx_lim_q <= lim_new; // R17
            end
            // Clearing a done flag restarts its count
            if (tdone_clr || !te) begin
                tx_cnt_q <= '0; // R11
            end else if (tx_load) begin
                tx_cnt_q <= tx_cnt_q + ssp_pkg::CNT_W'(1);
            end
            if (rdone_clr || !re) begin
                rx_cnt_q <= '0; // R11
            end else if (rx_push) begin
                rx_cnt_q <= rx_cnt_q + ssp_pkg::CNT_W'(1);
            end
        end
    end

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_s1_q <= 1'b1;
            sck_s2_q <= 1'b1;
            sck_s3_q <= 1'b1;
            rxd_s1_q <= 1'b1;
            rxd_s2_q <= 1'b1;
        end else begin
            sck_s1_q <= sck_i;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            rxd_s1_q <= rxd_i;
            rxd_s2_q <= rxd_s1_q;
        end
    end

    // ==========================================================
    // Internal clock: sixteen half periods per character
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_q  <= ssp_pkg::GEN_IDLE;
            sck_q  <= 1'b1;
            div_q  <= 8'h00;
            half_q <= 4'h0;
        end else begin
            case (gen_q)
                ssp_pkg::GEN_IDLE: begin
                    sck_q  <= 1'b1; // R24
                    div_q  <= 8'h00;
                    half_q <= 4'h0;
                    if (want_clk) begin
                        gen_q <= ssp_pkg::GEN_RUN; // R1
                    end
                end
                ssp_pkg::GEN_RUN: begin
                    if (tick) begin
                        div_q  <= 8'h00;
                        sck_q  <= ~sck_q;
                        half_q <= half_q + 4'h1;
                        if (half_q == ssp_pkg::LAST_HALF) begin
                            gen_q <= ssp_pkg::GEN_IDLE; // R24
                        end
                    end else begin
                        div_q <= div_q + 8'h01;
                    end
                end
                default: begin
                    gen_q <= ssp_pkg::GEN_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Shift registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy_q <= 1'b0;
            tx_sh_q   <= 8'h00;
            tx_bit_q  <= 3'h0;
            rx_sh_q   <= 8'h00;
            rx_bit_q  <= 3'h0;
            txd_o     <= 1'b1;
        end else begin
            if (!te) begin
                tx_busy_q <= 1'b0;
                tx_bit_q  <= 3'h0;
            end else if (tx_load) begin
                tx_busy_q <= 1'b1;
                tx_sh_q   <= tx_head;
                tx_bit_q  <= 3'h0;
            end else if (tx_byte_end) begin
                tx_busy_q <= 1'b0; // Last bit stays on the line
            end else if (tx_busy_q && fall_ev) begin
                txd_o   <= tx_sh_q[0]; // R25
                tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            end else if (tx_busy_q && rise_ev) begin
                tx_bit_q <= tx_bit_q + 3'h1;
            end
            if (!rx_run) begin
                rx_bit_q <= 3'h0;
            end else if (rx_sample) begin
                rx_sh_q  <= rx_byte_val; // R2
                rx_bit_q <= rx_bit_q + 3'h1;
            end
        end
    end

    // ==========================================================
    // Registered pin and interrupt outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_o    <= 1'b1;
            sck_oe   <= 1'b0;
            txd_oe   <= 1'b0;
            tx_irq   <= 1'b0;
            rx_irq   <= 1'b0;
            irq_code <= 2'h0;
        end else begin
            sck_o    <= sck_q;
            sck_oe   <= intclk & (te | re);
            txd_oe   <= te;
            tx_irq   <= irq_tx; // R6 R7
            rx_irq   <= irq_rx; // R6 R8
            irq_code <= irq_rx ? 2'h1 : (irq_tx ? 2'h2 : 2'h0); // R9
        end
    end

    // ==========================================================
    // FIFOs
    ssp_fifo #(
        .W     (8),
        .DEPTH (DEPTH)
    ) u_tx_fifo (
        .clk   (pclk),
        .rst_n (presetn),
        .clr   (fctl_q[ssp_pkg::FCTL_TRST]),
        .push  (push_tx),
        .wdata (pwdata[7:0]),
        .pop   (tx_load),
        .rdata (tx_head),
        .level (tx_lvl),
        .full  (tx_full),
        .empty (tx_empty)
    );

    ssp_fifo #(
        .W     (8),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .clk   (pclk),
        .rst_n (presetn),
        .clr   (fctl_q[ssp_pkg::FCTL_RRST]), // R21
        .push  (rx_push),
        .wdata (rx_byte_val),
        .pop   (pop_rx),
        .rdata (rx_head),
        .level (rx_lvl),
        .full  (rx_full),
        .empty (rx_empty)
    );

    // Full flag of the transmit side is reported only via the count register
    wire unused_ok = tx_full & rx_empty;
endmodule

//--- test/ssp_peer.sv
// Purpose: Far-side peer that owns the external serial clock
// Assumes: 160 ns clock period, idle high outside frames
// Notes:   Samples late in the high half, as data holds fall to fall
module ssp_peer (
    output logic      sck,
    output logic      rxd,
    input  wire logic txd
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Byte exchange
    initial {sck, rxd} = 2'b11;
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        #7;
        for (int i = 0; i < 8; i++) begin
            {sck, rxd} = {1'b0, d[i]};
            #80;
            sck = 1'b1;
            #80;
            q[i] = txd;
        end
        #400;
    endtask
endmodule

//--- test/ssp_props.sv
// Purpose: Port-level checks for the serial port top
// Assumes: One pclk domain, presetn active low
// Notes:   Irq outputs lag their causes by one edge
module ssp_props (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       sck_o,
    input wire logic       sck_oe,
    input wire logic       dma_burst,
    input wire logic       tx_irq,
    input wire logic       rx_irq,
    input wire logic [1:0] irq_code
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable && pwrite;
    // ==========================================================
    // Interrupt lines and serial clock
    a_rx_burst_mask: assert property (dma_burst |=> !rx_irq) else $error("rx irq in burst");
    a_tx_burst_mask: assert property (dma_burst |=> !tx_irq) else $error("tx irq in burst");
    a_rx_code_wins: assert property (rx_irq |-> irq_code == 2'b01) else $error("rx code lost");
    a_tx_code_only: assert property (tx_irq && !rx_irq |-> irq_code == 2'b10) else $error("tx code bad");
    a_code_idle: assert property (!tx_irq && !rx_irq && !$past(dma_burst) |-> irq_code == 2'b00) else $error("code");
    a_rx_irq_drop: assert property ($fell(rx_irq) |-> $past(dma_burst) || $past(acc) || $past(acc, 2)) else $error("rx");
    a_tx_irq_drop: assert property ($fell(tx_irq) |-> $past(dma_burst) || $past(acc) || $past(acc, 2)) else $error("tx");
    a_sck_idle_high: assert property (!sck_oe |-> sck_o) else $error("sck not high");
    c_both_irq: cover property (rx_irq && tx_irq);
    c_burst: cover property (dma_burst && $past(rx_irq));
    c_irq_clear: cover property ($fell(rx_irq));
endmodule
bind ssp_top ssp_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .sck_o(sck_o), .sck_oe(sck_oe), .dma_burst(dma_burst), .tx_irq(tx_irq), .rx_irq(rx_irq), .irq_code(irq_code));

//--- test/sync_serial_fifo_stop_ctrl_tb_top.sv
// Purpose: Self-checking bench for the serial port top
// Assumes: Peer owns the serial clock, internal clock left off
// Notes:   FIFO depth cut to 16 to keep runs short
module sync_serial_fifo_stop_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, presetn = 1'b0, dma_burst = 1'b0, re;
    logic [7:0]  paddr = 8'h00, got;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic        pready, pslverr, sck_o, sck_oe, peer_sck, rxd, txd_o, txd_oe, tx_irq, rx_irq;
    logic [1:0]  irq_code;
    int          miscompares = 0, num_checks = 0;
    wire logic   sck_w = sck_oe ? sck_o : peer_sck;
    // ==========================================================
    // Design, peer and bus tasks
    ssp_top #(.DEPTH(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck_i(sck_w),
        .sck_o(sck_o), .sck_oe(sck_oe), .rxd_i(rxd), .txd_o(txd_o), .txd_oe(txd_oe), .dma_burst(dma_burst),
        .tx_irq(tx_irq), .rx_irq(rx_irq), .irq_code(irq_code));
    ssp_peer u_peer (.sck(peer_sck), .rxd(rxd), .txd(txd_o));
    initial forever #10 pclk = ~pclk;
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 64);
        rv = prdata;
        re = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
        if (pready !== 1'b1) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, rv, x);
    endtask
    task automatic xchg(input logic [7:0] d, input logic [7:0] x);
        u_peer.xfer(d, got);
        @(posedge pclk);
        chk("txd", {24'h0, got}, {24'h0, x});
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd("bad", 8'h20, 32'h0);
        chk("err", {31'h0, re}, 32'h1);
        apb(1'b1, ssp_pkg::ADDR_LINE, 32'h102);
        apb(1'b1, ssp_pkg::ADDR_LINE, 32'h2);
        apb(1'b1, ssp_pkg::ADDR_TXD, 32'ha5);
        apb(1'b1, ssp_pkg::ADDR_TXD, 32'h3c);
        apb(1'b1, ssp_pkg::ADDR_CTRL, 32'hf);
        xchg(8'h5a, 8'ha5);
        rd("st1", ssp_pkg::ADDR_STAT, 32'h6);
        xchg(8'hc3, 8'h3c);
        rd("st2", ssp_pkg::ADDR_STAT, 32'h7);
        chk("irq", {27'h0, txd_oe, tx_irq, rx_irq, irq_code}, 32'h1d);
        xchg(8'hff, 8'h00);
        rd("lvl", ssp_pkg::ADDR_CNT, 32'h2);
        rd("rx0", ssp_pkg::ADDR_RXD, 32'h5a);
        apb(1'b1, ssp_pkg::ADDR_FCTL, 32'h1);
        apb(1'b1, ssp_pkg::ADDR_FCTL, 32'h0);
        dma_burst <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("mask", {30'h0, tx_irq, rx_irq}, 32'h0);
        dma_burst <= 1'b0;
        apb(1'b1, ssp_pkg::ADDR_LINE, 32'h102);
        apb(1'b1, ssp_pkg::ADDR_TXD, 32'h81);
        apb(1'b1, ssp_pkg::ADDR_TXD, 32'h7e);
        apb(1'b1, ssp_pkg::ADDR_STAT, 32'h7);
        rd("keep", ssp_pkg::ADDR_STAT, 32'h7);
        apb(1'b1, ssp_pkg::ADDR_STAT, 32'h0);
        xchg(8'h01, 8'h81);
        xchg(8'h80, 8'h7e);
        rd("st3", ssp_pkg::ADDR_STAT, 32'h7);
        rd("rx2", ssp_pkg::ADDR_RXD, 32'h01);
        summarize();
    end
endmodule
